//--- src/lfw_pkg.sv
package lfw_pkg;

   // Slave addresses (7-bit)
   localparam logic [6:0] SLAVE_ADDR_LOW = 7'h20;
   localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h24;

   // Register map
   localparam logic [7:0] REG_CONFIG = 8'h10;
   localparam logic [7:0] REG_FADE_OUT_TIMING = 8'h11;
   localparam logic [7:0] REG_FADE_IN_TIMING = 8'h12;

   // Configuration register fields
   localparam int RUN_BIT = 0;
   localparam int AUTO_WAKE_ENABLE_BIT = 1;
   localparam int EXT_CLOCK_SELECT_BIT = 3;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] FADE_OUT_RESET = 8'h00;
   localparam logic [7:0] FADE_IN_RESET = 8'h00;

   // Timing fields inside the fade registers
   localparam int RAMP_CODE_LSB = 0;
   localparam int HOLD_CODE_LSB = 3;
   localparam int CODE_W = 3;
   localparam logic [2:0] CODE_OFF = 3'h0;

   // Fade timing, in PWM clock periods
   localparam longint FADE_UNIT_US = 62500;
   localparam longint PWM_NOM_HZ = 32000;
   localparam int TIMER_W = 18;
   localparam logic [TIMER_W-1:0] HOLD_UNIT_TICKS_DEF = TIMER_W'(FADE_UNIT_US * PWM_NOM_HZ / 64'd1000000);
   localparam int DAC_LEVELS = 8;
   localparam logic [TIMER_W-1:0] STEP_UNIT_TICKS_DEF = TIMER_W'(HOLD_UNIT_TICKS_DEF / DAC_LEVELS);

   // Wake timeout, in PWM clock periods
   localparam int WAKE_W = 8;
   localparam logic [WAKE_W-1:0] WAKE_TICKS = 8'h80;

   // DAC
   localparam logic [2:0] DAC_FULL = 3'h7;
   localparam logic [2:0] DAC_ZERO = 3'h0;

   // Serial bus
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   // Synchroniser lanes
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_RSTN = 2;
   localparam int PIN_ADS = 3;
   localparam int PIN_N = 4;
   localparam logic [3:0] PIN_IDLE = 4'hF;

   typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} lfw_bus_e;
   typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} lfw_kind_e;
   typedef enum logic [2:0] {F_SHUT, F_UP, F_ON, F_HOLD, F_FADE} lfw_fade_e;

endpackage

//--- src/lfw_top.sv
`timescale 1ns/100ps
module lfw_top #(
   parameter logic [lfw_pkg::TIMER_W-1:0] HOLD_UNIT_TICKS = lfw_pkg::HOLD_UNIT_TICKS_DEF,
   parameter logic [lfw_pkg::TIMER_W-1:0] STEP_UNIT_TICKS = lfw_pkg::STEP_UNIT_TICKS_DEF
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pwm_clk,
   input wire logic rst_in_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic addr_select_pin,
   input wire logic [2:0] global_current,
   output logic [7:0] ext_reg_raddr,
   input wire logic [7:0] ext_reg_rdata,
   output logic ext_reg_wr,
   output logic [7:0] ext_reg_waddr,
   output logic [7:0] ext_reg_wdata,
   output logic [2:0] fade_dac,
   output logic shutdown,
   output logic holdoff_active,
   output logic fadeoff_active,
   output logic rampup_active,
   output logic ext_clock_select,
   output logic int_osc_run
);

   // PWM clock domain: reset sync and an event toggle per PWM period
   logic pwm_rst_s1_q;
   logic pwm_rst_s2_q;
   logic pwm_tgl_q;

   always_ff @(posedge pwm_clk) begin
      pwm_rst_s1_q <= reset;
      pwm_rst_s2_q <= pwm_rst_s1_q;
   end

   always_ff @(posedge pwm_clk) begin
      if (pwm_rst_s2_q) begin
         pwm_tgl_q <= 1'b0;
      end else begin
         pwm_tgl_q <= ~pwm_tgl_q;
      end
   end

   // Toggle crossing into ref_clk, one tick per PWM period
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_prev_q;
   logic pwm_tick;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_prev_q <= 1'b0;
      end else begin
         tgl_s1_q <= pwm_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_prev_q <= tgl_s2_q;
      end
   end

   assign pwm_tick = tgl_s2_q ^ tgl_prev_q;

   // Pin synchronisers
   logic [lfw_pkg::PIN_N-1:0] pin_s1_q;
   logic [lfw_pkg::PIN_N-1:0] pin_s2_q;
   logic [lfw_pkg::PIN_N-1:0] pin_prev_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_s1_q <= lfw_pkg::PIN_IDLE;
         pin_s2_q <= lfw_pkg::PIN_IDLE;
         pin_prev_q <= lfw_pkg::PIN_IDLE;
      end else begin
         pin_s1_q <= {addr_select_pin, rst_in_n, sda_in, scl_in};
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   logic scl_s;
   logic sda_s;
   logic rstn_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic rstn_rise;
   logic [6:0] my_addr;

   assign scl_s = pin_s2_q[lfw_pkg::PIN_SCL];
   assign sda_s = pin_s2_q[lfw_pkg::PIN_SDA];
   assign rstn_s = pin_s2_q[lfw_pkg::PIN_RSTN];
   assign scl_rise = scl_s & ~pin_prev_q[lfw_pkg::PIN_SCL];
   assign scl_fall = ~scl_s & pin_prev_q[lfw_pkg::PIN_SCL];
   assign bus_start = scl_s & pin_prev_q[lfw_pkg::PIN_SCL] & ~sda_s & pin_prev_q[lfw_pkg::PIN_SDA];
   assign bus_stop = scl_s & pin_prev_q[lfw_pkg::PIN_SCL] & sda_s & ~pin_prev_q[lfw_pkg::PIN_SDA];
   assign rstn_rise = rstn_s & ~pin_prev_q[lfw_pkg::PIN_RSTN];
   assign my_addr = pin_s2_q[lfw_pkg::PIN_ADS] ? lfw_pkg::SLAVE_ADDR_HIGH : lfw_pkg::SLAVE_ADDR_LOW;

   // Serial slave state
   lfw_pkg::lfw_bus_e bus_q;
   lfw_pkg::lfw_kind_e kind_q;
   logic [3:0] bitcnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic rw_q;
   logic nack_q;
   logic oe_n_q;
   logic [7:0] ptr_q;
   logic [7:0] config_q;
   logic [7:0] fade_out_q;
   logic [7:0] fade_in_q;
   logic [7:0] rd_data;
   logic byte_done;
   logic addr_ev;
   logic cmd_ev;
   logic wr_ev;
   logic rd_load_ev;

   assign byte_done = scl_fall && bus_q == lfw_pkg::I_RX && bitcnt_q == lfw_pkg::BYTE_BITS;
   assign addr_ev = byte_done && kind_q == lfw_pkg::K_ADDR && shift_q[7:1] == my_addr;
   assign cmd_ev = byte_done && kind_q == lfw_pkg::K_CMD;
   assign wr_ev = byte_done && kind_q == lfw_pkg::K_DATA;
   assign rd_load_ev = scl_fall && ((bus_q == lfw_pkg::I_ACK && rw_q) || (bus_q == lfw_pkg::I_TXACK && !nack_q));

   always_comb begin
      case (ptr_q)
         lfw_pkg::REG_CONFIG: rd_data = config_q;
         lfw_pkg::REG_FADE_OUT_TIMING: rd_data = fade_out_q;
         lfw_pkg::REG_FADE_IN_TIMING: rd_data = fade_in_q;
         default: rd_data = ext_reg_rdata;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset || !rstn_s) begin
         bus_q <= lfw_pkg::I_IDLE;
         kind_q <= lfw_pkg::K_ADDR;
         bitcnt_q <= '0;
         shift_q <= '0;
         tx_q <= '0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (bus_start) begin
         bus_q <= lfw_pkg::I_RX;
         kind_q <= lfw_pkg::K_ADDR;
         bitcnt_q <= '0;
         rw_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (bus_stop) begin
         bus_q <= lfw_pkg::I_IDLE;
         oe_n_q <= 1'b1;
      end else begin
         case (bus_q)
            lfw_pkg::I_RX: begin
               if (scl_rise && bitcnt_q != lfw_pkg::BYTE_BITS) begin
                  shift_q <= {shift_q[6:0], sda_s};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end
               if (byte_done) begin
                  if (kind_q == lfw_pkg::K_ADDR && !addr_ev) begin
                     bus_q <= lfw_pkg::I_IDLE;
                  end else begin
                     bus_q <= lfw_pkg::I_ACK;
                     oe_n_q <= 1'b0;
                     if (kind_q == lfw_pkg::K_ADDR) begin
                        rw_q <= shift_q[0];
                     end
                  end
               end
            end
            lfw_pkg::I_ACK: begin
               if (scl_fall) begin
                  bitcnt_q <= '0;
                  if (rw_q) begin
                     bus_q <= lfw_pkg::I_TX;
                     tx_q <= {rd_data[6:0], 1'b0};
                     oe_n_q <= rd_data[7];
                  end else begin
                     bus_q <= lfw_pkg::I_RX;
                     oe_n_q <= 1'b1;
                     kind_q <= (kind_q == lfw_pkg::K_ADDR) ? lfw_pkg::K_CMD : lfw_pkg::K_DATA;
                  end
               end
            end
            lfw_pkg::I_TX: begin
               if (scl_fall) begin
                  if (bitcnt_q == lfw_pkg::LAST_TX_BIT) begin
                     bus_q <= lfw_pkg::I_TXACK;
                     oe_n_q <= 1'b1;
                  end else begin
                     bitcnt_q <= bitcnt_q + 4'h1;
                     tx_q <= {tx_q[6:0], 1'b0};
                     oe_n_q <= tx_q[7];
                  end
               end
            end
            lfw_pkg::I_TXACK: begin
               if (scl_rise) begin
                  nack_q <= sda_s;
               end
               if (scl_fall) begin
                  bitcnt_q <= '0;
                  if (nack_q) begin
                     bus_q <= lfw_pkg::I_IDLE;
                  end else begin
                     bus_q <= lfw_pkg::I_TX;
                     tx_q <= {rd_data[6:0], 1'b0};
                     oe_n_q <= rd_data[7];
                  end
               end
            end
            default: begin
               bus_q <= lfw_pkg::I_IDLE;
               oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   // Register pointer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ptr_q <= '0;
      end else if (cmd_ev) begin
         ptr_q <= shift_q;
      end else if (wr_ev || rd_load_ev) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // Wake timer
   logic wake_armed_q;
   logic [lfw_pkg::WAKE_W-1:0] wake_cnt_q;
   logic wake_fire;

   assign wake_fire = wake_armed_q && rstn_s && !addr_ev && pwm_tick && wake_cnt_q == lfw_pkg::WAKE_TICKS - 8'h01;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wake_armed_q <= 1'b0;
         wake_cnt_q <= '0;
      end else if (!rstn_s) begin
         wake_armed_q <= 1'b0;
         wake_cnt_q <= '0;
      end else if (rstn_rise && config_q[lfw_pkg::AUTO_WAKE_ENABLE_BIT]) begin
         wake_armed_q <= 1'b1;
         wake_cnt_q <= '0;
      end else if (wake_armed_q) begin
         if (addr_ev || wake_fire) begin
            wake_armed_q <= 1'b0;
         end else if (pwm_tick) begin
            wake_cnt_q <= wake_cnt_q + 8'h01;
         end
      end
   end

   // Local registers and pass-through writes
   logic local_hit;

   assign local_hit = ptr_q == lfw_pkg::REG_CONFIG || ptr_q == lfw_pkg::REG_FADE_OUT_TIMING
                      || ptr_q == lfw_pkg::REG_FADE_IN_TIMING;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         config_q <= lfw_pkg::CONFIG_RESET;
         fade_out_q <= lfw_pkg::FADE_OUT_RESET;
         fade_in_q <= lfw_pkg::FADE_IN_RESET;
      end else begin
         if (wr_ev && ptr_q == lfw_pkg::REG_CONFIG) begin
            config_q <= shift_q;
         end
         if (wr_ev && ptr_q == lfw_pkg::REG_FADE_OUT_TIMING) begin
            fade_out_q <= shift_q;
         end
         if (wr_ev && ptr_q == lfw_pkg::REG_FADE_IN_TIMING) begin
            fade_in_q <= shift_q;
         end
         if (addr_ev && wake_armed_q) begin
            config_q[lfw_pkg::AUTO_WAKE_ENABLE_BIT] <= 1'b0;
         end
         if (wake_fire) begin
            config_q[lfw_pkg::RUN_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ext_reg_wr <= 1'b0;
         ext_reg_waddr <= '0;
         ext_reg_wdata <= '0;
      end else begin
         ext_reg_wr <= wr_ev && !local_hit;
         if (wr_ev) begin
            ext_reg_waddr <= ptr_q;
            ext_reg_wdata <= shift_q;
         end
      end
   end

   // Fade sequencer
   function automatic logic [lfw_pkg::TIMER_W-1:0] span(input logic [lfw_pkg::TIMER_W-1:0] unit,
                                                        input logic [2:0] code);
      span = unit << (code - 3'h1);
   endfunction

   lfw_pkg::lfw_fade_e fade_q;
   logic [2:0] level_q;
   logic [lfw_pkg::TIMER_W-1:0] timer_q;
   logic [2:0] ramp_in_code;
   logic [2:0] ramp_out_code;
   logic [2:0] hold_code;
   logic [lfw_pkg::TIMER_W-1:0] step_ticks;
   logic [lfw_pkg::TIMER_W-1:0] hold_ticks;
   logic run;
   logic step_done;
   logic hold_done;

   assign run = config_q[lfw_pkg::RUN_BIT];
   assign ramp_in_code = fade_in_q[lfw_pkg::RAMP_CODE_LSB +: lfw_pkg::CODE_W];
   assign ramp_out_code = fade_out_q[lfw_pkg::RAMP_CODE_LSB +: lfw_pkg::CODE_W];
   assign hold_code = fade_out_q[lfw_pkg::HOLD_CODE_LSB +: lfw_pkg::CODE_W];
   assign step_ticks = span(STEP_UNIT_TICKS, (fade_q == lfw_pkg::F_UP) ? ramp_in_code : ramp_out_code);
   assign hold_ticks = span(HOLD_UNIT_TICKS, hold_code);
   assign step_done = pwm_tick && timer_q == step_ticks - 18'h00001;
   assign hold_done = pwm_tick && timer_q == hold_ticks - 18'h00001;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fade_q <= lfw_pkg::F_SHUT;
         level_q <= lfw_pkg::DAC_ZERO;
         timer_q <= '0;
      end else begin
         case (fade_q)
            lfw_pkg::F_SHUT: begin
               timer_q <= '0;
               level_q <= lfw_pkg::DAC_ZERO;
               if (run && ramp_in_code == lfw_pkg::CODE_OFF) begin
                  fade_q <= lfw_pkg::F_ON;
                  level_q <= lfw_pkg::DAC_FULL;
               end else if (run) begin
                  fade_q <= lfw_pkg::F_UP;
               end
            end
            lfw_pkg::F_UP: begin
               if (!run) begin
                  timer_q <= '0;
                  fade_q <= (ramp_out_code == lfw_pkg::CODE_OFF) ? lfw_pkg::F_SHUT : lfw_pkg::F_FADE;
               end else if (step_done) begin
                  timer_q <= '0;
                  if (level_q == lfw_pkg::DAC_FULL) begin
                     fade_q <= lfw_pkg::F_ON;
                  end else begin
                     level_q <= level_q + 3'h1;
                  end
               end else if (pwm_tick) begin
                  timer_q <= timer_q + 18'h00001;
               end
            end
            lfw_pkg::F_ON: begin
               timer_q <= '0;
               level_q <= lfw_pkg::DAC_FULL;
               if (!run) begin
                  if (hold_code != lfw_pkg::CODE_OFF) begin
                     fade_q <= lfw_pkg::F_HOLD;
                  end else if (ramp_out_code != lfw_pkg::CODE_OFF) begin
                     fade_q <= lfw_pkg::F_FADE;
                  end else begin
                     fade_q <= lfw_pkg::F_SHUT;
                  end
               end
            end
            lfw_pkg::F_HOLD: begin
               if (run) begin
                  fade_q <= lfw_pkg::F_ON;
               end else if (hold_done) begin
                  timer_q <= '0;
                  fade_q <= (ramp_out_code == lfw_pkg::CODE_OFF) ? lfw_pkg::F_SHUT : lfw_pkg::F_FADE;
               end else if (pwm_tick) begin
                  timer_q <= timer_q + 18'h00001;
               end
            end
            lfw_pkg::F_FADE: begin
               if (run) begin
                  timer_q <= '0;
                  if (ramp_in_code == lfw_pkg::CODE_OFF) begin
                     fade_q <= lfw_pkg::F_ON;
                  end else begin
                     fade_q <= lfw_pkg::F_UP;
                  end
               end else if (step_done) begin
                  timer_q <= '0;
                  if (level_q == lfw_pkg::DAC_ZERO) begin
                     fade_q <= lfw_pkg::F_SHUT;
                  end else begin
                     level_q <= level_q - 3'h1;
                  end
               end else if (pwm_tick) begin
                  timer_q <= timer_q + 18'h00001;
               end
            end
            default: begin
               fade_q <= lfw_pkg::F_SHUT;
               level_q <= lfw_pkg::DAC_ZERO;
               timer_q <= '0;
            end
         endcase
      end
   end

   // DAC output capped by the global current setting
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fade_dac <= lfw_pkg::DAC_ZERO;
      end else if (fade_q == lfw_pkg::F_SHUT) begin
         fade_dac <= lfw_pkg::DAC_ZERO;
      end else begin
         fade_dac <= (level_q > global_current) ? global_current : level_q;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n = oe_n_q;
   assign ext_reg_raddr = ptr_q;
   assign shutdown = fade_q == lfw_pkg::F_SHUT;
   assign holdoff_active = fade_q == lfw_pkg::F_HOLD;
   assign fadeoff_active = fade_q == lfw_pkg::F_FADE;
   assign rampup_active = fade_q == lfw_pkg::F_UP;
   assign ext_clock_select = config_q[lfw_pkg::EXT_CLOCK_SELECT_BIT];
   assign int_osc_run = ~ext_clock_select & (run | wake_armed_q | (fade_q != lfw_pkg::F_SHUT));

endmodule

//--- verif/lfw_i2c_master.sv
`timescale 1ns/100ps
module lfw_i2c_master #(parameter int H = 4) (
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic start();
      sda_m = 1'b1;
      w(3);
      scl = 1'b1;
      w(H);
      sda_m = 1'b0;
      w(H);
      scl = 1'b0;
      w(2);
   endtask
   task automatic stop();
      sda_m = 1'b0;
      w(3);
      scl = 1'b1;
      w(H);
      sda_m = 1'b1;
      w(H);
   endtask
   // Data moves only with scl low
   task automatic bt(input logic b, output logic r);
      sda_m = b;
      w(H);
      scl = 1'b1;
      w(H);
      r = sda;
      scl = 1'b0;
      w(4);
   endtask
   task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
      bt(!mack, r);
      ack = !r;
   endtask
endmodule

//--- verif/lfw_monitor.sv
`timescale 1ns/100ps
module lfw_monitor (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic rst_in_n,
   input wire logic scl_in,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic ext_reg_wr,
   input wire logic [7:0] ext_reg_waddr,
   input wire logic [2:0] global_current,
   input wire logic [2:0] fade_dac,
   input wire logic shutdown,
   input wire logic holdoff_active,
   input wire logic fadeoff_active,
   input wire logic rampup_active,
   input wire logic ext_clock_select,
   input wire logic int_osc_run
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_pin_low; !rst_in_n [*4]; endsequence
   sequence s_hold2; holdoff_active ##1 holdoff_active; endsequence
   property p_od; sda_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("sda driven high");
   property p_scl_low; $changed(sda_oe_n) && rst_in_n |-> !scl_in; endproperty
   a_scl_low: assert property (p_scl_low) else $error("sda moved while scl high");
   property p_idle; s_pin_low |-> sda_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("sda pulled with reset pin low");
   property p_cap; $stable(global_current) |-> fade_dac <= global_current; endproperty
   a_cap: assert property (p_cap) else $error("dac above global current");
   property p_dark; shutdown ##1 shutdown |-> fade_dac == 3'h0; endproperty
   a_dark: assert property (p_dark) else $error("dac lit in shutdown");
   property p_hold; s_hold2 |-> fade_dac == global_current; endproperty
   a_hold: assert property (p_hold) else $error("hold not at full");
   property p_up;
      rampup_active && $past(rampup_active) && $stable(global_current) |-> fade_dac >= $past(fade_dac);
   endproperty
   a_up: assert property (p_up) else $error("ramp up fell");
   property p_down;
      fadeoff_active && $past(fadeoff_active) && $stable(global_current) |-> fade_dac <= $past(fade_dac);
   endproperty
   a_down: assert property (p_down) else $error("fade rose");
   property p_osc;
      (rampup_active || holdoff_active || fadeoff_active) && !ext_clock_select |-> int_osc_run;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator stopped in sequence");
   property p_one; $onehot0({shutdown, holdoff_active, fadeoff_active, rampup_active}); endproperty
   a_one: assert property (p_one) else $error("two fade states");
   property p_ext;
      ext_reg_wr |-> (ext_reg_waddr < lfw_pkg::REG_CONFIG || ext_reg_waddr > lfw_pkg::REG_FADE_IN_TIMING)
         ##1 !ext_reg_wr;
   endproperty
   a_ext: assert property (p_ext) else $error("bad external write");
endmodule

//--- verif/lfw_top_tb_top.sv
`timescale 1ns/100ps
module lfw_top_tb_top;
   localparam logic [17:0] HU = 18'h10;
   localparam logic [17:0] SU = 18'h2;
   logic ref_clk, pwm_clk, reset, rst_in_n, addr_select_pin;
   logic [2:0] global_current, hc, fc, uc, fade_dac;
   logic scl_in, sda_m, sda_in, sda_o, sda_oe_n, a, ext_reg_wr, shutdown;
   logic holdoff_active, fadeoff_active, rampup_active, ext_clock_select, int_osc_run;
   logic [7:0] ext_reg_raddr, ext_reg_rdata, ext_reg_waddr, ext_reg_wdata, q0, q1, p, d, rmask;
   logic [6:0] ad;
   logic [15:0] wq[$];
   int n_fail = 0, n_compared = 0, cyc = 0, c_up = 0, c_hold = 0, c_fade = 0;
   assign sda_in = sda_m & (sda_oe_n | sda_o);
   assign ext_reg_rdata = ext_reg_raddr ^ rmask;
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      pwm_clk = 1'b0;
      #1.3;
      forever #6 pwm_clk = ~pwm_clk;
   end
   lfw_i2c_master m (.ref_clk, .sda(sda_in), .scl(scl_in), .sda_m);
   lfw_top #(.HOLD_UNIT_TICKS(HU), .STEP_UNIT_TICKS(SU)) dut (.ref_clk, .reset, .pwm_clk, .rst_in_n,
      .scl_in, .sda_in, .sda_o, .sda_oe_n, .addr_select_pin, .global_current, .ext_reg_raddr,
      .ext_reg_rdata, .ext_reg_wr, .ext_reg_waddr, .ext_reg_wdata, .fade_dac, .shutdown,
      .holdoff_active, .fadeoff_active, .rampup_active, .ext_clock_select, .int_osc_run);
   always @(posedge ref_clk) begin
      cyc += 1;
      c_up += rampup_active;
      c_hold += holdoff_active;
      c_fade += fadeoff_active;
      if (ext_reg_wr) wq.push_back({ext_reg_waddr, ext_reg_wdata});
      if (cyc > 90000) begin
         n_fail++;
         conclude();
      end
   end
   task conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input string s, input logic [7:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   // Duration in ref cycles against ticks at 12 ns, code 0 means instant
   function automatic logic [7:0] span(int n, logic [2:0] c, int unit);
      int e;
      e = c == 0 ? 0 : 12 * (unit << (c - 1));
      return 8'(n * 10 >= e * 3 / 4 && n * 10 <= e * 5 / 4 + 60);
   endfunction
   task wr(input logic [7:0] ptr, d0, d1, input int n);
      m.start();
      m.xb({ad, 1'b0}, 0, q0, a);
      chk("addr ack", 8'(a), 8'h01);
      m.xb(ptr, 0, q0, a);
      if (n > 0) m.xb(d0, 0, q0, a);
      if (n > 1) m.xb(d1, 0, q0, a);
      chk("data ack", 8'(a), 8'h01);
      m.stop();
   endtask
   task rd(input logic [7:0] ptr);
      m.start();
      m.xb({ad, 1'b0}, 0, q0, a);
      m.xb(ptr, 0, q0, a);
      m.start();
      m.xb({ad, 1'b1}, 0, q0, a);
      m.xb(8'hFF, 1, q0, a);
      m.xb(8'hFF, 0, q1, a);
      m.stop();
   endtask
   task clr();
      c_up = 0;
      c_hold = 0;
      c_fade = 0;
   endtask
   initial begin
      reset = 1'b1;
      rst_in_n = 1'b1;
      addr_select_pin = 1'b0;
      global_current = 3'h7;
      void'($urandom(78));
      rmask = 8'($urandom);
      repeat (4) @(posedge ref_clk);
      #1 reset = 0;
      m.w(4);
      chk("shutdown", 8'(shutdown), 8'h01);
      ad = lfw_pkg::SLAVE_ADDR_LOW;
      rd(lfw_pkg::REG_CONFIG);
      chk("config", q0, lfw_pkg::CONFIG_RESET);
      chk("fade out", q1, lfw_pkg::FADE_OUT_RESET);
      rd(lfw_pkg::REG_FADE_IN_TIMING);
      chk("fade in", q0, lfw_pkg::FADE_IN_RESET);
      for (int i = 0; i < 4; i++) begin
         addr_select_pin = i[1];
         m.w(4);
         m.start();
         m.xb({i[0] ? lfw_pkg::SLAVE_ADDR_HIGH : lfw_pkg::SLAVE_ADDR_LOW, 1'b0}, 0, q0, a);
         m.stop();
         chk("addr match", 8'(a), 8'(i[0] == i[1]));
      end
      addr_select_pin = 0;
      for (int i = 0; i < 3; i++) begin
         p = i == 0 ? 8'hFF : 8'($urandom_range(14));
         d = 8'($urandom);
         rmask = 8'($urandom);
         wq.delete();
         wr(p, d, ~d, 2);
         chk("writes", 8'(wq.size()), 8'h02);
         chk("waddr0", wq[0][15:8], p);
         chk("wdata0", wq[0][7:0], d);
         chk("waddr1", wq[1][15:8], p + 8'h01);
         chk("wdata1", wq[1][7:0], ~d);
         rd(p);
         chk("rdata0", q0, p ^ rmask);
         chk("rdata1", q1, (p + 8'h01) ^ rmask);
      end
      wr(lfw_pkg::REG_CONFIG, 8'h08, 8'h00, 1);
      chk("ext select", 8'(ext_clock_select), 8'h01);
      wr(lfw_pkg::REG_CONFIG, 8'h00, 8'h00, 1);
      chk("ext select", 8'(ext_clock_select), 8'h00);
      for (int c = 0; c < 8; c++) begin
         hc = 3'($urandom_range(3));
         fc = 3'($urandom);
         uc = 3'(c);
         global_current = 3'($urandom_range(7, 1));
         wr(lfw_pkg::REG_FADE_OUT_TIMING, {2'b00, hc, fc}, {5'h00, uc}, 2);
         rd(lfw_pkg::REG_FADE_OUT_TIMING);
         chk("fade out rb", q0, {2'b00, hc, fc});
         chk("fade in rb", q1, {5'h00, uc});
         clr();
         wr(lfw_pkg::REG_CONFIG, 8'h01, 8'h00, 1);
         for (int k = 0; k < 4000 && (rampup_active || shutdown); k++) m.w(1);
         chk("dac full", 8'(fade_dac), 8'(global_current));
         chk("ramp up time", span(c_up, uc, 8 * SU), 8'h01);
         clr();
         wr(lfw_pkg::REG_CONFIG, 8'h00, 8'h00, 1);
         for (int k = 0; k < 4000 && !shutdown; k++) m.w(1);
         m.w(2);
         chk("dac zero", 8'(fade_dac), 8'h00);
         chk("hold time", span(c_hold, hc, HU), 8'h01);
         chk("fade time", span(c_fade, fc, 8 * SU), 8'h01);
      end
      wr(lfw_pkg::REG_FADE_OUT_TIMING, 8'h00, 8'h00, 2);
      wr(lfw_pkg::REG_CONFIG, 8'h02, 8'h00, 1);
      rst_in_n = 0;
      m.w(5);
      rst_in_n = 1;
      m.w(100);
      rst_in_n = 0;
      m.w(5);
      rst_in_n = 1;
      m.w(140);
      chk("no early wake", 8'(shutdown), 8'h01);
      m.w(40);
      chk("woken", 8'(shutdown), 8'h00);
      rd(lfw_pkg::REG_CONFIG);
      chk("run set", 8'(q0[0]), 8'h01);
      wr(lfw_pkg::REG_CONFIG, 8'h02, 8'h00, 1);
      rst_in_n = 0;
      m.w(5);
      rst_in_n = 1;
      m.w(4);
      wr(lfw_pkg::REG_FADE_IN_TIMING, 8'h00, 8'h00, 1);
      m.w(200);
      chk("wake cancelled", 8'(shutdown), 8'h01);
      rd(lfw_pkg::REG_CONFIG);
      chk("config cleared", q0, 8'h00);
      rst_in_n = 0;
      m.w(4);
      m.start();
      m.xb({ad, 1'b0}, 0, q0, a);
      m.stop();
      chk("ignored", 8'(a), 8'h00);
      rst_in_n = 1;
      m.w(4);
      conclude();
   end
endmodule
bind lfw_top lfw_monitor mon (.ref_clk, .reset, .rst_in_n, .scl_in, .sda_o, .sda_oe_n, .ext_reg_wr,
   .ext_reg_waddr, .global_current, .fade_dac, .shutdown, .holdoff_active, .fadeoff_active,
   .rampup_active, .ext_clock_select, .int_osc_run);
